// *** logic/fwa_map.svh ***
// register offsets, field positions and reset values of the alert unit
`ifndef FWA_MAP_SVH
`define FWA_MAP_SVH
`define FWA_OFS_OPER  8'h00
`define FWA_OFS_CLR   8'h04
`define FWA_OFS_STAT  8'h08
`define FWA_OFS_AEN   8'h0c
`define FWA_OFS_LIM0  8'h10
`define FWA_OFS_LIM6  8'h28
`define FWA_OFS_ADDR  8'h2c
`define FWA_OFS_RB0   8'h30
`define FWA_OFS_RB3   8'h3c
`define FWA_OFS_PK0   8'h40
`define FWA_OFS_PK2   8'h48
`define FWA_ST_W      13
`define FWA_B_UVF     0
`define FWA_B_OVF     1
`define FWA_B_OCF     2
`define FWA_B_COMM_ERR 3
`define FWA_B_CUR_REG 4
`define FWA_B_IOC     5
`define FWA_B_IW2     6
`define FWA_B_VINUV   7
`define FWA_B_VINOV   8
`define FWA_B_VOUTUV  9
`define FWA_B_VOUTOV  10
`define FWA_B_PINOP   11
`define FWA_B_FET     12
`define FWA_OP_ON_BIT 7
`define FWA_AINV_BIT  16
`define FWA_IW2P_BIT  16
`define FWA_AEN_RST   13'h1000
`define FWA_LIM_HI    16'h0fff
`define FWA_LIM_LO    16'h0000
`define FWA_LIM_PWR   16'h7fff
`define FWA_ADDR_RST  7'h10
`define FWA_ARA_ADDR  7'h0c
`endif

// *** logic/fwa_pkg.sv ***
// types of the alert unit
package fwa_pkg;
  typedef enum logic [2:0] {SM_IDLE, SM_ADDR, SM_AACK, SM_TX, SM_RNACK} fwa_smb_t;
endpackage

// *** logic/fwa_alert.sv ***
// fault and warning latching with alert pin and alert response answer
`timescale 1ns/1ps
`include "fwa_map.svh"
module fwa_alert (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  input  wire logic        I_UV_PIN,
  input  wire logic        I_OV_PIN,
  input  wire logic        I_OC_TMO,
  input  wire logic        I_CURRENT_REGULATION_ACTIVE_WARNING,
  input  wire logic        I_FET_BAD,
  input  wire logic        I_COMM_ERROR_WARNING,
  input  wire logic        I_SMP_VLD,
  input  wire logic [11:0] I_VIN,
  input  wire logic [11:0] I_VOUT,
  input  wire logic [11:0] I_IOUT,
  input  wire logic [15:0] I_PIN,
  input  wire logic        I_SCL,
  input  wire logic        I_SDA,
  output logic             O_SDA_O,
  output logic             O_SDA_OE,
  output logic             O_ALERT_OUTPUT_PIN_O,
  output logic             O_ALERT_OUTPUT_PIN_OE,
  output logic             O_HS_EN
);
  function automatic logic f_gt(input logic [15:0] a, input logic [15:0] b);
    f_gt = (a > b);
  endfunction
  logic [6:0]            s1_ff;
  logic [6:0]            s2_ff;
  logic [1:0]            s3_ff;
  logic                  scl_s;
  logic                  sda_s;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  smb_start;
  logic                  smb_stop;
  logic                  op_on_ff;
  logic                  fault_off_ff;
  logic                  hs_en_ff;
  logic [`FWA_ST_W-1:0]  st_ff;
  logic [`FWA_ST_W-1:0]  nxt_st;
  logic [`FWA_ST_W-1:0]  aen_ff;
  logic                  ainv_ff;
  logic [`FWA_ST_W-1:0]  cond;
  logic [`FWA_ST_W-1:0]  rise;
  logic                  alert_ff;
  logic                  nxt_alert;
  logic                  oe_ff;
  logic                  zero_ff;
  logic [15:0]           lim_ff [0:6];
  logic                  iw2_under_ff;
  logic [15:0]           rb_ff [0:3];
  logic [11:0]           pk_ff [0:2];
  logic [6:0]            own_ff;
  logic                  addr_ph;
  logic                  wr_ff;
  logic [7:0]            wa_ff;
  logic [31:0]           hrdata_ff;
  logic                  ready_ff;
  logic [31:0]           rd_mux;
  logic                  wr_op;
  logic                  reon;
  logic                  clr_cmd;
  logic                  clr;
  fwa_pkg::fwa_smb_t     sm_ff;
  logic [3:0]            cnt_ff;
  logic [7:0]            sh_ff;
  logic                  sda_oe_ff;
  logic                  ara_win;
  logic                  ara_lost;
  // two flops per pin; reset to idle levels so no false fault follows
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      s1_ff <= 7'h60;
      s2_ff <= 7'h60;
      s3_ff <= 2'h3;
    end else begin
      s1_ff <= {I_SDA, I_SCL, I_FET_BAD, I_CURRENT_REGULATION_ACTIVE_WARNING,
                I_OC_TMO, I_OV_PIN, I_UV_PIN};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff[6:5];
    end
  end

  assign scl_s     = s2_ff[5];
  assign sda_s     = s2_ff[6];
  assign scl_rise  = scl_s & ~s3_ff[0];
  assign scl_fall  = ~scl_s & s3_ff[0];
  assign smb_start = scl_s & s3_ff[0] & s3_ff[1] & ~sda_s;
  assign smb_stop  = scl_s & s3_ff[0] & ~s3_ff[1] & sda_s;

  // fault levels come straight from pins, no enable can mask them
  always_comb begin
    cond                 = '0;
    cond[`FWA_B_UVF]     = s2_ff[0];
    cond[`FWA_B_OVF]     = s2_ff[1];
    cond[`FWA_B_OCF]     = s2_ff[2];
    cond[`FWA_B_COMM_ERR] = I_COMM_ERROR_WARNING;
    cond[`FWA_B_CUR_REG]  = s2_ff[3];
    cond[`FWA_B_FET]     = s2_ff[4];
    // adc warnings are sample pulses so a clear re-arms them
    if (I_SMP_VLD) begin
      cond[`FWA_B_IOC]    = f_gt({4'h0, I_IOUT}, lim_ff[2]);
      cond[`FWA_B_IW2]    = iw2_under_ff ? f_gt(lim_ff[6], {4'h0, I_IOUT})
                                         : f_gt({4'h0, I_IOUT}, lim_ff[6]);
      cond[`FWA_B_VINUV]  = f_gt(lim_ff[4], {4'h0, I_VIN});
      cond[`FWA_B_VINOV]  = f_gt({4'h0, I_VIN}, lim_ff[3]);
      cond[`FWA_B_VOUTUV] = f_gt(lim_ff[1], {4'h0, I_VOUT});
      cond[`FWA_B_VOUTOV] = f_gt({4'h0, I_VOUT}, lim_ff[0]);
      cond[`FWA_B_PINOP]  = f_gt(I_PIN, lim_ff[5]);
    end
  end

  // ahb-lite slave, zero wait states
  assign addr_ph = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign wr_op   = wr_ff & (wa_ff == `FWA_OFS_OPER);
  assign reon    = wr_op & I_HWDATA[`FWA_OP_ON_BIT] & ~op_on_ff;
  assign clr_cmd = wr_ff & (wa_ff == `FWA_OFS_CLR);
  assign clr     = clr_cmd | reon;

  always_comb begin
    rd_mux = 32'h0;
    if (I_HADDR[7:0] == `FWA_OFS_OPER)
      rd_mux[`FWA_OP_ON_BIT] = op_on_ff;
    else if (I_HADDR[7:0] == `FWA_OFS_STAT)
      rd_mux[`FWA_ST_W-1:0] = st_ff;
    else if (I_HADDR[7:0] == `FWA_OFS_AEN)
      rd_mux = {15'h0, ainv_ff, 3'h0, aen_ff};
    else if (I_HADDR[7:0] >= `FWA_OFS_LIM0 && I_HADDR[7:0] <= `FWA_OFS_LIM6) begin
      rd_mux[15:0] = lim_ff[3'(I_HADDR[4:2] - 3'h4)];
      if (I_HADDR[7:0] == `FWA_OFS_LIM6)
        rd_mux[`FWA_IW2P_BIT] = iw2_under_ff;
    end else if (I_HADDR[7:0] == `FWA_OFS_ADDR)
      rd_mux[6:0] = own_ff;
    else if (I_HADDR[7:0] >= `FWA_OFS_RB0 && I_HADDR[7:0] <= `FWA_OFS_RB3)
      rd_mux[15:0] = rb_ff[I_HADDR[3:2]];
    else if (I_HADDR[7:0] >= `FWA_OFS_PK0 && I_HADDR[7:0] <= `FWA_OFS_PK2)
      rd_mux[11:0] = pk_ff[I_HADDR[3:2]];
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      wr_ff     <= 1'b0;
      wa_ff     <= 8'h00;
      hrdata_ff <= 32'h0;
      ready_ff  <= 1'b1;
      zero_ff   <= 1'b0;
    end else begin
      wr_ff    <= addr_ph & I_HWRITE;
      wa_ff    <= I_HADDR[7:0];
      ready_ff <= 1'b1;
      zero_ff  <= 1'b0;
      if (addr_ph & ~I_HWRITE)
        hrdata_ff <= rd_mux;
    end
  end

  // software-written configuration
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      op_on_ff     <= 1'b1;
      aen_ff       <= `FWA_AEN_RST;
      ainv_ff      <= 1'b0;
      own_ff       <= `FWA_ADDR_RST;
      iw2_under_ff <= 1'b0;
      lim_ff[0]    <= `FWA_LIM_HI;
      lim_ff[1]    <= `FWA_LIM_LO;
      lim_ff[2]    <= `FWA_LIM_HI;
      lim_ff[3]    <= `FWA_LIM_HI;
      lim_ff[4]    <= `FWA_LIM_LO;
      lim_ff[5]    <= `FWA_LIM_PWR;
      lim_ff[6]    <= `FWA_LIM_LO;
    end else if (wr_ff) begin
      if (wr_op)
        op_on_ff <= I_HWDATA[`FWA_OP_ON_BIT];
      if (wa_ff == `FWA_OFS_AEN) begin
        aen_ff  <= I_HWDATA[`FWA_ST_W-1:0];
        ainv_ff <= I_HWDATA[`FWA_AINV_BIT];
      end
      if (wa_ff == `FWA_OFS_ADDR)
        own_ff <= I_HWDATA[6:0];
      if (wa_ff >= `FWA_OFS_LIM0 && wa_ff <= `FWA_OFS_LIM6)
        lim_ff[3'(wa_ff[4:2] - 3'h4)] <= I_HWDATA[15:0];
      if (wa_ff == `FWA_OFS_LIM6)
        iw2_under_ff <= I_HWDATA[`FWA_IW2P_BIT];
    end
  end

  // raw adc codes, no scaling; a peak is cleared only by a write to its own offset
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      for (int i = 0; i < 4; i++)
        rb_ff[i] <= 16'h0;
      for (int i = 0; i < 3; i++)
        pk_ff[i] <= 12'h0;
    end else begin
      if (I_SMP_VLD) begin
        rb_ff[0] <= {4'h0, I_VIN};
        rb_ff[1] <= {4'h0, I_VOUT};
        rb_ff[2] <= {4'h0, I_IOUT};
        rb_ff[3] <= I_PIN;
        if (f_gt({4'h0, I_IOUT}, {4'h0, pk_ff[0]}))
          pk_ff[0] <= I_IOUT;
        if (f_gt({4'h0, I_VIN}, {4'h0, pk_ff[1]}))
          pk_ff[1] <= I_VIN;
        if (f_gt({4'h0, I_VOUT}, {4'h0, pk_ff[2]}))
          pk_ff[2] <= I_VOUT;
      end
      if (wr_ff && wa_ff >= `FWA_OFS_PK0 && wa_ff <= `FWA_OFS_PK2)
        pk_ff[wa_ff[3:2]] <= 12'h0;
    end
  end

  // set beats clear: a bit survives a clear while its cause holds
  assign nxt_st = clr ? cond : (st_ff | cond);
  assign rise   = nxt_st & ~st_ff & aen_ff;

  always_ff @(posedge I_MCLK) begin
    if (I_RST)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // of the faults only uv, ov and oc drop the switch; re-enable needs off then on
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      fault_off_ff <= 1'b0;
      hs_en_ff     <= 1'b0;
    end else begin
      if (|cond[`FWA_B_OCF:`FWA_B_UVF])
        fault_off_ff <= 1'b1;
      else if (reon)
        fault_off_ff <= 1'b0;
      hs_en_ff <= op_on_ff & ~fault_off_ff;
    end
  end

  always_comb begin
    nxt_alert = alert_ff;
    if (|rise)
      nxt_alert = 1'b1;
    else if (clr_cmd | ara_win)
      nxt_alert = 1'b0;
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      alert_ff <= 1'b0;
      oe_ff    <= 1'b0;
    end else begin
      alert_ff <= nxt_alert;
      oe_ff    <= alert_ff ^ ainv_ff;
    end
  end

  // alert response answer; only this byte is served on the link
  assign ara_win  = (sm_ff == fwa_pkg::SM_RNACK) & scl_rise;
  assign ara_lost = (sm_ff == fwa_pkg::SM_TX) & scl_rise & ~sda_oe_ff & ~sda_s;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      sm_ff     <= fwa_pkg::SM_IDLE;
      cnt_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      sda_oe_ff <= 1'b0;
    end else if (smb_start) begin
      sm_ff     <= fwa_pkg::SM_ADDR;
      cnt_ff    <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else if (smb_stop) begin
      sm_ff     <= fwa_pkg::SM_IDLE;
      sda_oe_ff <= 1'b0;
    end else begin
      case (sm_ff)
        fwa_pkg::SM_ADDR: begin
          if (scl_rise) begin
            sh_ff  <= {sh_ff[6:0], sda_s};
            cnt_ff <= cnt_ff + 4'h1;
          end
          if (scl_fall && cnt_ff == 4'h8) begin
            if (sh_ff == {`FWA_ARA_ADDR, 1'b1} && alert_ff) begin
              sda_oe_ff <= 1'b1;
              sm_ff     <= fwa_pkg::SM_AACK;
            end else begin
              sm_ff <= fwa_pkg::SM_IDLE;
            end
          end
        end
        fwa_pkg::SM_AACK: begin
          if (scl_fall) begin
            cnt_ff    <= 4'h0;
            sh_ff     <= {own_ff, 1'b1};
            sda_oe_ff <= ~own_ff[6];
            sm_ff     <= fwa_pkg::SM_TX;
          end
        end
        fwa_pkg::SM_TX: begin
          // a released one read back low means a lower address wins
          if (ara_lost) begin
            sm_ff <= fwa_pkg::SM_IDLE;
          end else if (scl_rise) begin
            cnt_ff <= cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (cnt_ff == 4'h8) begin
              sda_oe_ff <= 1'b0;
              sm_ff     <= fwa_pkg::SM_RNACK;
            end else begin
              sh_ff     <= {sh_ff[6:0], 1'b1};
              sda_oe_ff <= ~sh_ff[6];
            end
          end
        end
        fwa_pkg::SM_RNACK: begin
          if (scl_rise)
            sm_ff <= fwa_pkg::SM_IDLE;
        end
        default: begin
          sm_ff <= fwa_pkg::SM_IDLE;
        end
      endcase
    end
  end
  assign O_HRDATA              = hrdata_ff;
  assign O_HREADYOUT           = ready_ff;
  assign O_HRESP               = zero_ff;
  assign O_SDA_O               = zero_ff;
  assign O_SDA_OE              = sda_oe_ff;
  assign O_ALERT_OUTPUT_PIN_O  = zero_ff;
  assign O_ALERT_OUTPUT_PIN_OE = oe_ff;
  assign O_HS_EN               = hs_en_ff;
  default clocking dc @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  sequence s_nack_win;
    (sm_ff == fwa_pkg::SM_RNACK) && scl_rise && !(|rise);
  endsequence
  sequence s_lose;
    ara_lost && alert_ff && !clr_cmd;
  endsequence
  fault_off_a: assert property ((|cond[2:0]) |=> ##1 !O_HS_EN)
    else $error("fault did not switch output off");
  warn_keep_a: assert property ($rose(fault_off_ff) |-> $past(|cond[2:0]))
    else $error("output dropped without a fault");
  latch_hold_a: assert property (!clr |=> ((st_ff & $past(st_ff)) == $past(st_ff)))
    else $error("latched status bit lost");
  clr_keep_a: assert property (clr |=> st_ff == $past(cond))
    else $error("clear did not follow cause");
  edge_alert_a: assert property ((|rise) |=> alert_ff ##1 (O_ALERT_OUTPUT_PIN_OE != ainv_ff))
    else $error("enabled edge gave no alert");
  clr_release_a: assert property (clr_cmd && !(|rise) |=> !alert_ff)
    else $error("clear did not release alert");
  ara_release_a: assert property (s_nack_win |=> !alert_ff)
    else $error("winner kept alert");
  lose_keep_a: assert property (s_lose |=> alert_ff && sm_ff == fwa_pkg::SM_IDLE)
    else $error("loser dropped alert");
  hold_rel_a: assert property (!alert_ff && !(|rise) |=> !alert_ff)
    else $error("alert rose with no new edge");
  pol_a: assert property (alert_ff && !ainv_ff && $stable(ainv_ff) |=> O_ALERT_OUTPUT_PIN_OE)
    else $error("alert not pulled low");
  strict_a: assert property (I_SMP_VLD && I_VOUT == lim_ff[1][11:0] && lim_ff[1][15:12] == 4'h0
    |-> !cond[`FWA_B_VOUTUV])
    else $error("equal value set a warning");
endmodule // fwa_alert

// *** testbench/fwa_smb_host.sv ***
// smbus host model issuing alert response reads, with an optional lower-address rival
`timescale 1ns/1ps

module fwa_smb_host (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  localparam logic [7:0] ARA_RD     = {7'h0c, 1'b1};
  // rival sits below our own address, so it always wins arbitration
  localparam logic [7:0] RIVAL_BYTE = 8'h11;
  logic host_low;
  logic rival_low;

  assign o_sda_low = host_low | rival_low;

  initial begin
    o_scl     = 1'b1; // scl stands still between frames
    host_low  = 1'b0;
    rival_low = 1'b0;
  end

  task automatic clk_bit(input logic drv_low, input logic rv_low, output logic seen);
    host_low  = drv_low;
    rival_low = rv_low;
    #20 o_scl = 1'b1;
    #20 seen = i_sda;
    #20 o_scl = 1'b0;
    #20;
  endtask

  task automatic ara(input logic rival, output logic [7:0] data, output logic ack);
    logic b;
    host_low = 1'b1;
    #20 o_scl = 1'b0;
    #20;
    for (int i = 7; i >= 0; i--) clk_bit(~ARA_RD[i], 1'b0, b);
    clk_bit(1'b0, rival, ack);
    for (int i = 7; i >= 0; i--) clk_bit(1'b0, rival & ~RIVAL_BYTE[i], data[i]);
    clk_bit(1'b0, 1'b0, b);
    host_low = 1'b1;
    #20 o_scl = 1'b1;
    #20 host_low = 1'b0;
    #40;
  endtask
endmodule // fwa_smb_host

// *** testbench/fwa_alert_tb.sv ***
// self-checking bench for the fault, warning and alert unit
`timescale 1ns/1ps

module fwa_alert_tb;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [2:0]  fpin;
  logic        creg, fet, cerr, smp;
  logic [11:0] vin, vout, iout;
  logic [15:0] pin;
  logic        scl, sda, sda_low, sda_o, sda_oe, alert_o, alert_oe, hs_en, ack;
  logic [7:0]  ara_d;
  logic [31:0] rdv;
  int          compares;
  int          miscompares;
  logic [31:0] lim_rst [7] = '{32'hfff, 32'h0, 32'hfff, 32'hfff, 32'h0, 32'h7fff, 32'h0};

  // open-drain line with pull-up: low while anyone drives a zero
  assign sda = !(sda_low | (sda_oe & !sda_o));

  fwa_alert i_fwa_alert (
    .I_MCLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_UV_PIN(fpin[0]),
    .I_OV_PIN(fpin[1]), .I_OC_TMO(fpin[2]), .I_CURRENT_REGULATION_ACTIVE_WARNING(creg),
    .I_FET_BAD(fet), .I_COMM_ERROR_WARNING(cerr),
    .I_SMP_VLD(smp), .I_VIN(vin), .I_VOUT(vout), .I_IOUT(iout), .I_PIN(pin), .I_SCL(scl),
    .I_SDA(sda), .O_SDA_O(sda_o), .O_SDA_OE(sda_oe), .O_ALERT_OUTPUT_PIN_O(alert_o),
    .O_ALERT_OUTPUT_PIN_OE(alert_oe), .O_HS_EN(hs_en));

  fwa_smb_host i_fwa_smb_host (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one single word transfer; the wait on hready is cut only by the watchdog
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask

  task automatic sample(input logic [11:0] v);
    @(posedge clk);
    vin <= v;
    vout <= v;
    iout <= v;
    pin <= {4'h0, v};
    smp <= 1'b1;
    @(posedge clk) smp <= 1'b0;
    cyc(4);
  endtask

  task automatic cerr_pulse();
    @(posedge clk) cerr <= 1'b1;
    @(posedge clk) cerr <= 1'b0;
    cyc(4);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200us;
    miscompares++;
    give_verdict();
  end

  initial begin
    {rst, hsel, haddr, htrans, hwrite, hwdata, fpin, creg, fet, cerr, smp} = '0;
    {vin, vout, iout, pin, compares, miscompares} = '0;
    rst = 1'b1;
    cyc(9);
    chk(alert_oe, 1'b0);
    @(posedge clk) rst <= 1'b0;
    cyc(5);
    chk(alert_oe, 1'b0);
    chk(hs_en, 1'b1);
    wr(8'h04, 32'h0);
    rd(8'h0c, 32'h1000);
    rd(8'h08, 32'h0);
    chk(hresp, 1'b0);
    chk(hready, 1'b1);
    wr(8'h0c, 32'h0);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) fpin[k] <= 1'b1;
      cyc(6);
      chk(hs_en, 1'b0);
      wr(8'h04, 32'h0);
      rd(8'h08, 32'h1 << k);
      chk(alert_oe, 1'b0);
      @(posedge clk) fpin[k] <= 1'b0;
      cyc(6);
      rd(8'h08, 32'h1 << k);
      chk(hs_en, 1'b0);
      wr(8'h00, 32'h0);
      wr(8'h00, 32'h80);
      cyc(3);
      rd(8'h08, 32'h0);
      chk(hs_en, 1'b1);
    end
    for (int a = 8'h10; a <= 8'h28; a += 4) wr(a[7:0], 32'h800);
    sample(12'h800);
    rd(8'h08, 32'h0);
    sample(12'h801);
    sample(12'h7ff);
    @(posedge clk) creg <= 1'b1;
    @(posedge clk) cerr <= 1'b1;
    @(posedge clk) cerr <= 1'b0;
    creg <= 1'b0;
    cyc(6);
    rd(8'h08, 32'h0ff8);
    chk(hs_en, 1'b1);
    for (int a = 8'h30; a <= 8'h3c; a += 4) rd(a[7:0], 32'h7ff);
    for (int a = 8'h40; a <= 8'h48; a += 4) rd(a[7:0], 32'h801);
    wr(8'h40, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h28, 32'h800);
    for (int i = 0; i < 7; i++) wr(8'h10 + 8'(4 * i), lim_rst[i]);
    wr(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h0c, 32'h1000);
    @(posedge clk) fet <= 1'b1;
    cyc(6);
    chk(alert_oe, 1'b1);
    wr(8'h04, 32'h0);
    cyc(2);
    chk(alert_oe, 1'b0);
    rd(8'h08, 32'h1000);
    cyc(10);
    chk(alert_oe, 1'b0);
    @(posedge clk) fet <= 1'b0;
    cyc(4);
    wr(8'h04, 32'h0);
    wr(8'h0c, 32'h200);
    wr(8'h14, 32'h100);
    sample(12'h100);
    chk(alert_oe, 1'b0);
    sample(12'h0ff);
    chk(alert_oe, 1'b1);
    wr(8'h04, 32'h0);
    cyc(2);
    chk(alert_oe, 1'b0);
    sample(12'h0ff);
    chk(alert_oe, 1'b1);
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h0c, 32'h10008);
    cyc(3);
    chk(alert_oe, 1'b1);
    cerr_pulse();
    chk(alert_oe, 1'b0);
    wr(8'h04, 32'h0);
    wr(8'h0c, 32'h8);
    cerr_pulse();
    chk(alert_oe, 1'b1);
    i_fwa_smb_host.ara(1'b1, ara_d, ack);
    chk(ara_d, 8'h11);
    cyc(4);
    chk(alert_oe, 1'b1);
    repeat (2) if (alert_oe === 1'b1) i_fwa_smb_host.ara(1'b0, ara_d, ack);
    chk(ack, 1'b0);
    chk(ara_d[7:1], 7'h10);
    chk(sda_o, 1'b0);
    cyc(2);
    chk(alert_oe, 1'b0);
    rd(8'h08, 32'h8);
    cerr_pulse();
    chk(alert_oe, 1'b0);
    wr(8'h04, 32'h0);
    cerr_pulse();
    chk(alert_oe, 1'b1);
    chk(alert_o, 1'b0);
    wr(8'h04, 32'h0);
    cyc(3);
    i_fwa_smb_host.ara(1'b0, ara_d, ack);
    chk(ack, 1'b1);
    give_verdict();
  end
endmodule // fwa_alert_tb
